// ---- hw/adcopc_pkg.sv ----
// constants and types for the converter output and power control block
//
// What this block does
// R1: stabilizer active gives a regenerated falling edge, nominal 50% duty.
// R2: stabilizer treated as non-functional below 40 MHz sample clock.
// R3: after a clock rate change, relock takes 1.5 to 5 us.
// R4: while unlocked, stabilizer is bypassed; timing follows input duty.
// R5: power mode field 01 in register 0x08 selects full power-down.
// R6: in full power-down all output drivers are high impedance.
// R7: power-down stops reference, buffer, bias and internal clock.
// R8: power mode field 10 selects standby, reference kept powered.
// R9: output coding selectable: offset binary, twos complement, gray.
// R10: output disable bit 4 of output_mode_control three-states data pins.
// R11: each output sample appears 10 sample clocks after its input.
// R12: latched output data updates on each rising sample clock edge.
// R13: data clock out accompanies the data for external capture.
// R14: overrange flag comes from pipeline end, aligned, 10 cycles late.
// R15: overrange high only strictly beyond full scale; limit gives no flag.
// R16: offset binary: -FS 000, zero 800, +FS FFF.
// R17: twos complement is default: -FS 800, zero 000, +FS 7FF.
// R18: stabilizer enabled at power-up when divider ratio is not 1.
// R19: output mode output_mode_control resets to 0x01, twos complement.
// R20: power field 00 is normal; gray is offset binary xor shifted.
// R21: after power-down or standby, output invalid for 10 sample clocks.
package adcopc_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADCOPC_PWR_ADDR = 8'h08;
    localparam logic [7:0] ADCOPC_OUT_ADDR = 8'h14;
    localparam logic [7:0] ADCOPC_CLK_ADDR = 8'h09;
    localparam logic [7:0] ADCOPC_PWR_RESET = 8'h00;
    localparam logic [7:0] ADCOPC_OUT_RESET = 8'h01;
    localparam int ADCOPC_PWR_LSB = 0;
    localparam int ADCOPC_FMT_LSB = 0;
    localparam int ADCOPC_OEB_BIT = 4;
    localparam int ADCOPC_DCS_BIT = 0;
    // power mode field codes
    localparam logic [1:0] ADCOPC_PWR_NORMAL = 2'h0;
    localparam logic [1:0] ADCOPC_PWR_DOWN = 2'h1;
    localparam logic [1:0] ADCOPC_PWR_STBY = 2'h2;
    // output format field codes
    localparam logic [1:0] ADCOPC_FMT_OFFBIN = 2'h0;
    localparam logic [1:0] ADCOPC_FMT_TWOS = 2'h1;
    localparam logic [1:0] ADCOPC_FMT_GRAY = 2'h2;
    // ---------------------------------------------------------------
    // data path and timing
    // ---------------------------------------------------------------
    localparam int ADCOPC_WIDTH = 12;
    localparam int ADCOPC_LATENCY = 10;
    localparam logic [11:0] ADCOPC_CODE_MIN = 12'h000;
    localparam logic [11:0] ADCOPC_CODE_MAX = 12'hFFF;
    localparam int ADCOPC_CLK_MHZ = 250;
    localparam int ADCOPC_DCS_MIN_MHZ = 40;
    localparam int ADCOPC_RELOCK_MIN_NS = 1500;
    localparam int ADCOPC_RELOCK_MAX_NS = 5000;
    // worst-case relock wait: round up, cycles of 4 ns
    localparam int ADCOPC_RELOCK_CYC =
        (ADCOPC_RELOCK_MAX_NS * ADCOPC_CLK_MHZ + 999) / 1000;
    localparam int ADCOPC_RELOCK_MIN_CYC =
        (ADCOPC_RELOCK_MIN_NS * ADCOPC_CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {
        ADCOPC_RUN,
        ADCOPC_OFF,
        ADCOPC_WAKE
    } adcopc_pwr_e;
endpackage

// ---- hw/adcopc_coder.sv ----
// output coder: turns the offset binary pipeline word into the chosen code
`timescale 1ns/1ps
module adcopc_coder
    import adcopc_pkg::*;
(
    input wire logic [ADCOPC_WIDTH-1:0] offbin_in,
    input wire logic [1:0] format_in,
    output logic [ADCOPC_WIDTH-1:0] code_out
);
    // ---------------------------------------------------------------
    // coding
    // ---------------------------------------------------------------
    logic [ADCOPC_WIDTH-1:0] twos_word;
    logic [ADCOPC_WIDTH-1:0] gray_word;

    // twos complement is offset binary with the msb flipped
    assign twos_word = {~offbin_in[ADCOPC_WIDTH-1],
                        offbin_in[ADCOPC_WIDTH-2:0]}; // R17
    // gray: each bit xor the next more significant one
    assign gray_word = offbin_in ^ (offbin_in >> 1); // R20
    // select by format field; reserved code falls to offset binary
    assign code_out = (format_in == ADCOPC_FMT_TWOS) ? twos_word :
                      (format_in == ADCOPC_FMT_GRAY) ? gray_word :
                      offbin_in; // R9 R16
endmodule

// ---- hw/adcopc_top.sv ----
// converter digital back end: registers, pipeline, coding, outputs, power
`timescale 1ns/1ps
module adcopc_top
    import adcopc_pkg::*;
#(
    parameter int RELOCK_CYCLES = ADCOPC_RELOCK_CYC
)
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // quantised core sample, offset binary, plus beyond-limit flags
    input wire logic [ADCOPC_WIDTH-1:0] sample_in,
    input wire logic above_full_scale_in,
    input wire logic below_full_scale_in,
    // clock environment
    input wire logic [2:0] clock_divider_ratio_in,
    input wire logic clock_rate_low_in,
    input wire logic clock_rate_change_in,
    // register port, one byte per access
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // parallel data link
    output logic [ADCOPC_WIDTH-1:0] data_out,
    output logic data_oe_out,
    output logic overrange_out,
    output logic overrange_oe_out,
    output logic data_clock_out,
    output logic data_clock_oe_out,
    output logic data_valid_out,
    // analog control
    output logic reference_enable_out,
    output logic bias_enable_out,
    output logic core_clock_enable_out,
    output logic duty_cycle_stabilizer_out,
    output logic stabilizer_locked_out
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] power_mode_control;
    logic [7:0] output_mode_control;
    logic [7:0] clock_control;
    logic strap_done;

    logic wr_pwr;
    logic wr_out;
    logic wr_clk;
    logic [1:0] pwr_field;
    logic [1:0] fmt_field;
    logic output_disable_bit;
    logic dcs_req;
    logic [7:0] next_rdata;
    logic [2:0] reg_sel;

    // register select: one-hot over the three mapped addresses
    function automatic logic [2:0] reg_select(input logic [7:0] addr);
        return {addr == ADCOPC_CLK_ADDR,
                addr == ADCOPC_OUT_ADDR,
                addr == ADCOPC_PWR_ADDR};
    endfunction

    // write strobes share the select with the read mux
    assign reg_sel = reg_select(reg_addr_in);
    assign wr_pwr = reg_write_in && reg_sel[0];
    assign wr_out = reg_write_in && reg_sel[1];
    assign wr_clk = reg_write_in && reg_sel[2];
    assign pwr_field = power_mode_control[ADCOPC_PWR_LSB +: 2];
    assign fmt_field = output_mode_control[ADCOPC_FMT_LSB +: 2];
    assign output_disable_bit = output_mode_control[ADCOPC_OEB_BIT];
    assign dcs_req = clock_control[ADCOPC_DCS_BIT];

    // read mux; unmapped addresses read zero
    assign next_rdata =
        reg_sel[0] ? power_mode_control :
        reg_sel[1] ? output_mode_control :
        reg_sel[2] ? clock_control :
        8'h00;

    // register writes
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            power_mode_control <= ADCOPC_PWR_RESET;
            output_mode_control <= ADCOPC_OUT_RESET; // R19
        end else begin
            if (wr_pwr) begin
                power_mode_control <= reg_wdata_in; // R5 R8
            end
            if (wr_out) begin
                output_mode_control <= reg_wdata_in; // R9 R10
            end
        end
    end

    // stabilizer enable; default caught from divider after reset release
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            clock_control <= 8'h00;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            clock_control <= {7'h00,
                              clock_divider_ratio_in != 3'h0}; // R18
        end else if (wr_clk) begin
            clock_control <= reg_wdata_in;
        end
    end

    // read data
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rdata_out <= reg_read_in ? next_rdata : 8'h00;
            reg_rvalid_out <= reg_read_in;
        end
    end

    // ---------------------------------------------------------------
    // duty cycle stabilizer control
    // ---------------------------------------------------------------
    logic [15:0] relock_count;
    logic dcs_locked;
    logic dcs_usable;

    assign dcs_usable = dcs_req && !clock_rate_low_in; // R2

    // relock wait restarts on every rate change
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            relock_count <= 16'h0000;
            dcs_locked <= 1'b0;
        end else if (!dcs_usable || clock_rate_change_in) begin
            relock_count <= 16'h0000;
            dcs_locked <= 1'b0; // R3
        end else if (relock_count == 16'(RELOCK_CYCLES - 1)) begin
            dcs_locked <= 1'b1;
        end else begin
            relock_count <= relock_count + 16'h0001;
        end
    end

    // unlocked stabilizer is bypassed: regenerated edge only when locked
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            duty_cycle_stabilizer_out <= 1'b0;
            stabilizer_locked_out <= 1'b0;
        end else begin
            duty_cycle_stabilizer_out <= dcs_usable && dcs_locked; // R1 R4
            stabilizer_locked_out <= dcs_locked;
        end
    end

    // ---------------------------------------------------------------
    // power control
    // ---------------------------------------------------------------
    adcopc_pwr_e pwr_state;
    adcopc_pwr_e next_pwr_state;
    logic [3:0] wake_count;
    logic converting;
    logic powered_off;

    assign converting = (pwr_field == ADCOPC_PWR_NORMAL) ||
                        (pwr_field == 2'h3); // R20
    assign powered_off = (pwr_field == ADCOPC_PWR_DOWN);

    always_comb begin
        next_pwr_state = pwr_state;
        unique case (pwr_state)
            ADCOPC_RUN: begin
                if (!converting) begin
                    next_pwr_state = ADCOPC_OFF;
                end
            end
            ADCOPC_OFF: begin
                if (converting) begin
                    next_pwr_state = ADCOPC_WAKE;
                end
            end
            ADCOPC_WAKE: begin
                if (!converting) begin
                    next_pwr_state = ADCOPC_OFF;
                end else if (wake_count ==
                             4'(ADCOPC_LATENCY - 1)) begin
                    next_pwr_state = ADCOPC_RUN; // R21
                end
            end
            default: next_pwr_state = ADCOPC_OFF;
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwr_state <= ADCOPC_WAKE;
            wake_count <= 4'h0;
        end else begin
            pwr_state <= next_pwr_state;
            wake_count <= (pwr_state == ADCOPC_WAKE) ?
                          wake_count + 4'h1 : 4'h0;
        end
    end

    // analog enables; standby keeps the reference alive
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reference_enable_out <= 1'b1;
            bias_enable_out <= 1'b1;
            core_clock_enable_out <= 1'b1;
        end else begin
            reference_enable_out <= !powered_off; // R7 R8
            bias_enable_out <= converting; // R7
            core_clock_enable_out <= converting; // R7
        end
    end

    // ---------------------------------------------------------------
    // conversion pipeline
    // ---------------------------------------------------------------
    logic [ADCOPC_WIDTH-1:0] pipe_data [ADCOPC_LATENCY-1];
    logic pipe_or [ADCOPC_LATENCY-1];
    logic [ADCOPC_WIDTH-1:0] coded;
    logic [ADCOPC_WIDTH-1:0] clamped;
    logic beyond;

    // beyond flags only for strict excess; limit code alone is no flag
    assign beyond = above_full_scale_in || below_full_scale_in; // R15
    assign clamped = above_full_scale_in ? ADCOPC_CODE_MAX :
                     below_full_scale_in ? ADCOPC_CODE_MIN :
                     sample_in; // R16

    // nine stages here, the output flop makes ten; stage zero takes
    // the clamped word and its beyond flag
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pipe_data[0] <= '0;
            pipe_or[0] <= 1'b0;
        end else begin
            pipe_data[0] <= clamped; // R11
            pipe_or[0] <= beyond; // R14
        end
    end

    // later stages shift word and flag together, one step per edge
    for (genvar g = 1; g < ADCOPC_LATENCY - 1; g++) begin : g_stage
        always_ff @(posedge mclk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                pipe_data[g] <= '0;
                pipe_or[g] <= 1'b0;
            end else begin
                pipe_data[g] <= pipe_data[g-1]; // R11
                pipe_or[g] <= pipe_or[g-1]; // R14
            end
        end
    end

    adcopc_coder u_coder (
        .offbin_in(pipe_data[ADCOPC_LATENCY-2]),
        .format_in(fmt_field),
        .code_out(coded)
    );

    // ---------------------------------------------------------------
    // output stage
    // ---------------------------------------------------------------
    logic run_ok;
    assign run_ok = (pwr_state == ADCOPC_RUN);

    // output latch updates every rising edge
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_out <= '0;
            overrange_out <= 1'b0;
            data_valid_out <= 1'b0;
        end else begin
            data_out <= coded; // R12
            overrange_out <= pipe_or[ADCOPC_LATENCY-2]; // R14
            data_valid_out <= run_ok; // R21
        end
    end

    // drivers: power-down floats all, disable bit floats data only
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_oe_out <= 1'b0;
            overrange_oe_out <= 1'b0;
            data_clock_oe_out <= 1'b0;
        end else begin
            data_oe_out <= !powered_off && !output_disable_bit; // R6 R10
            overrange_oe_out <= !powered_off; // R6
            data_clock_oe_out <= !powered_off; // R6
        end
    end

    // data clock: toggles on every rising edge while converting, one transition per word
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_clock_out <= 1'b0;
        end else begin
            data_clock_out <= !data_clock_out && converting; // R13
        end
    end
endmodule

// ---- verif/adcopc_sva.sv ----
// assertion checker for the converter output and power control block
`timescale 1ns/1ps
module adcopc_sva
    import adcopc_pkg::*;
#(
    parameter int RELOCK_CYCLES = ADCOPC_RELOCK_CYC
)
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [ADCOPC_WIDTH-1:0] sample_in,
    input wire logic above_full_scale_in,
    input wire logic below_full_scale_in,
    input wire logic clock_rate_low_in,
    input wire logic clock_rate_change_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic [ADCOPC_WIDTH-1:0] data_out,
    input wire logic data_oe_out,
    input wire logic overrange_out,
    input wire logic overrange_oe_out,
    input wire logic data_clock_out,
    input wire logic data_clock_oe_out,
    input wire logic data_valid_out,
    input wire logic reference_enable_out,
    input wire logic core_clock_enable_out,
    input wire logic stabilizer_locked_out
);
    // ----------------
    // register shadows
    // ----------------
    logic [1:0] pm;
    logic [1:0] fm;
    logic ob;
    // mirror of power field, format field and output disable bit
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pm <= 2'h0;
            fm <= 2'h1;
            ob <= 1'b0;
        end else if (reg_write_in && reg_addr_in == 8'h08) begin
            pm <= reg_wdata_in[1:0];
        end else if (reg_write_in && reg_addr_in == 8'h14) begin
            fm <= reg_wdata_in[1:0];
            ob <= reg_wdata_in[4];
        end
    end
    default clocking dck @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);
    // ----------------
    // properties
    // ----------------
    a_pd_hiz: assert property ((pm == 2'h1) [*2] |->
        !data_oe_out && !overrange_oe_out && !data_clock_oe_out)
        else $error("outputs driven in power-down");
    a_pd_shutoff: assert property ((pm == 2'h1) [*2] |->
        !reference_enable_out && !core_clock_enable_out)
        else $error("reference or clock on in power-down");
    a_stby_ref: assert property ((pm == 2'h2) [*2] |->
        reference_enable_out && !core_clock_enable_out)
        else $error("standby enables wrong");
    a_oeb_hiz: assert property (ob [*2] |-> !data_oe_out)
        else $error("data driven while disabled");
    a_offbin_latency: assert property (data_valid_out && data_oe_out &&
        fm == 2'h0 && $past(fm) == 2'h0 &&
        !$past(above_full_scale_in || below_full_scale_in, 10)
        |-> data_out == $past(sample_in, 10))
        else $error("offset binary word wrong or late");
    a_twos_latency: assert property (data_valid_out && data_oe_out &&
        fm == 2'h1 && $past(fm) == 2'h1 &&
        !$past(above_full_scale_in || below_full_scale_in, 10)
        |-> data_out == ($past(sample_in, 10) ^ 12'h800))
        else $error("twos complement word wrong or late");
    a_or_align: assert property (data_valid_out |-> overrange_out ==
        $past(above_full_scale_in || below_full_scale_in, 10))
        else $error("overrange flag misaligned");
    a_dclk_toggle: assert property (data_valid_out &&
        core_clock_enable_out && $past(data_valid_out) |->
        data_clock_out != $past(data_clock_out))
        else $error("data clock did not toggle");
    a_relock_drop: assert property (clock_rate_change_in |-> ##2
        !stabilizer_locked_out)
        else $error("lock kept after rate change");
    a_low_rate: assert property (clock_rate_low_in [*3] |->
        !stabilizer_locked_out)
        else $error("lock shown at low clock rate");
    a_wake_gap: assert property (pm == 2'h0 && $past(pm) != 2'h0 &&
        $past(pm) != 2'h3 |-> !data_valid_out [*8])
        else $error("valid too soon after wake");
    a_rd_unmapped: assert property (reg_read_in && reg_addr_in != 8'h08 &&
        reg_addr_in != 8'h14 && reg_addr_in != 8'h09 |=>
        reg_rvalid_out && reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    c_pd_cycle: cover property (pm == 2'h1 ##1 pm == 2'h0);
    c_overrange: cover property (data_valid_out && overrange_out);
    c_relock: cover property ($rose(stabilizer_locked_out));
endmodule
bind adcopc_top adcopc_sva #(.RELOCK_CYCLES(RELOCK_CYCLES)) sva_u (.*);

// ---- verif/adcopc_capture.sv ----
// capture register model on the far side of the data link
`timescale 1ns/1ps
module adcopc_capture
    import adcopc_pkg::*;
(
    input wire logic [ADCOPC_WIDTH-1:0] bus_in,
    input wire logic data_clock_in,
    output logic [ADCOPC_WIDTH-1:0] word_out,
    output int words_out
);
    // ----------------
    // capture
    // ----------------
    int count = 0;
    assign words_out = count;
    // every data clock transition latches one word, 1 ns on, so the
    // word launched on the same edge has settled on the bus
    always @(data_clock_in) begin
        #1;
        word_out <= bus_in;
        count <= count + 1;
    end
endmodule

// ---- verif/adcopc_top_tb.sv ----
// self-checking bench for the converter output and power control block
`timescale 1ns/1ps
module adcopc_top_tb;
    import adcopc_pkg::*;
    localparam int RC = 8;
    localparam logic [11:0] SMP [8] = '{12'h000, 12'h800, 12'hFFF,
        12'h5A3, 12'h000, 12'hFFF, 12'h3C1, 12'h9E0};
    localparam logic [1:0] FLG [8] = '{2'h0, 2'h0, 2'h0, 2'h0,
        2'h1, 2'h2, 2'h2, 2'h1};
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [11:0] sample_in, data_out;
    logic above_full_scale_in, below_full_scale_in, clock_rate_low_in;
    logic clock_rate_change_in, reg_write_in, reg_read_in, reg_rvalid_out;
    logic [2:0] clock_divider_ratio_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic data_oe_out, overrange_out, overrange_oe_out, data_clock_out;
    logic data_clock_oe_out, data_valid_out, reference_enable_out;
    logic bias_enable_out, core_clock_enable_out, duty_cycle_stabilizer_out;
    logic stabilizer_locked_out;
    wire [11:0] dbus;
    wire dclk;
    int cap_n;
    logic [11:0] cap_w;
    int n_errors = 0;
    int total_checks = 0;
    // ----------------
    // clock, design, pins, capture model
    // ----------------
    always #2 mclk_in = ~mclk_in;
    adcopc_top #(.RELOCK_CYCLES(RC)) dut_u (.*);
    assign dbus = data_oe_out ? data_out : 12'hZZZ;
    assign dclk = data_clock_oe_out ? data_clock_out : 1'hZ;
    adcopc_capture cap_u (.bus_in(dbus), .data_clock_in(dclk),
        .word_out(cap_w), .words_out(cap_n));
    // ----------------
    // helpers
    // ----------------
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        chk({11'h000, got}, {11'h000, exp});
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        reg_write_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge mclk_in);
        reg_write_in = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk_in);
        reg_read_in = 1'b1;
        reg_addr_in = a;
        @(negedge mclk_in);
        reg_read_in = 1'b0;
        chk1(reg_rvalid_out, 1'b1);
        chk({4'h0, reg_rdata_out}, {4'h0, exp});
    endtask
    // expected word: clamp, then code as selected
    function logic [11:0] enc(input logic [1:0] f, input logic [11:0] s,
        input logic [1:0] fl);
        logic [11:0] o;
        o = fl[1] ? 12'hFFF : (fl[0] ? 12'h000 : s);
        case (f)
            2'h1: enc = o ^ 12'h800;
            2'h2: enc = o ^ (o >> 1);
            default: enc = o;
        endcase
    endfunction
    // ----------------
    // scenarios
    // ----------------
    task t_regs;
        rd(ADCOPC_OUT_ADDR, 8'h01);
        rd(ADCOPC_PWR_ADDR, 8'h00);
        rd(ADCOPC_CLK_ADDR, 8'h01);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
    endtask
    task t_code(input logic [1:0] f);
        int n0;
        wr(ADCOPC_OUT_ADDR, {6'h00, f});
        n0 = cap_n;
        for (int i = 0; i < 18; i++) begin
            @(negedge mclk_in);
            if (i >= 10) begin
                chk(data_out, enc(f, SMP[i-10], FLG[i-10]));
                chk1(overrange_out, |FLG[i-10]);
                chk(cap_w, enc(f, SMP[i-10], FLG[i-10]));
            end
            if (i < 8) begin
                sample_in = SMP[i];
                {above_full_scale_in, below_full_scale_in} = FLG[i];
            end
        end
        chk(12'(cap_n - n0), 12'h012);
    endtask
    task t_oeb;
        wr(ADCOPC_OUT_ADDR, 8'h11);
        repeat (3) @(negedge mclk_in);
        chk1(data_oe_out, 1'b0);
        chk1(overrange_oe_out, 1'b1);
        rd(ADCOPC_OUT_ADDR, 8'h11);
        wr(ADCOPC_OUT_ADDR, 8'h01);
        repeat (3) @(negedge mclk_in);
        chk1(data_oe_out, 1'b1);
    endtask
    task t_pwr(input logic [1:0] m);
        wr(ADCOPC_PWR_ADDR, {6'h00, m});
        repeat (3) @(negedge mclk_in);
        chk1(data_oe_out, m != 2'h1);
        chk1(reference_enable_out, m != 2'h1);
        chk1(core_clock_enable_out, 1'b0);
        chk1(bias_enable_out, 1'b0);
        rd(ADCOPC_PWR_ADDR, {6'h00, m});
        wr(ADCOPC_PWR_ADDR, 8'h00);
        repeat (11) @(negedge mclk_in);
        chk1(data_valid_out, 1'b0);
        repeat (1) @(negedge mclk_in);
        chk1(data_valid_out, 1'b1);
        chk1(core_clock_enable_out, 1'b1);
        chk1(bias_enable_out, 1'b1);
    endtask
    task t_dcs;
        @(negedge mclk_in);
        clock_rate_change_in = 1'b1;
        @(negedge mclk_in);
        clock_rate_change_in = 1'b0;
        @(negedge mclk_in);
        chk1(stabilizer_locked_out, 1'b0);
        chk1(duty_cycle_stabilizer_out, 1'b0);
        repeat (RC + 4) @(negedge mclk_in);
        chk1(stabilizer_locked_out, 1'b1);
        chk1(duty_cycle_stabilizer_out, 1'b1);
        clock_rate_low_in = 1'b1;
        repeat (RC + 4) @(negedge mclk_in);
        chk1(stabilizer_locked_out, 1'b0);
        clock_rate_low_in = 1'b0;
        repeat (RC + 4) @(negedge mclk_in);
        chk1(stabilizer_locked_out, 1'b1);
    endtask
    // second reset with divide by one: stabilizer stays off
    task t_rst;
        @(negedge mclk_in);
        clock_divider_ratio_in = 3'h0;
        reset_n_in = 1'b0;
        repeat (5) @(negedge mclk_in);
        reset_n_in = 1'b1;
        repeat (RC + 4) @(negedge mclk_in);
        rd(ADCOPC_CLK_ADDR, 8'h00);
        rd(ADCOPC_OUT_ADDR, 8'h01);
        chk1(duty_cycle_stabilizer_out, 1'b0);
        chk1(data_valid_out, 1'b1);
    endtask
    // main sequence
    initial begin
        sample_in = 12'h000;
        {above_full_scale_in, below_full_scale_in} = 2'h0;
        clock_divider_ratio_in = 3'h3;
        clock_rate_low_in = 1'b0;
        clock_rate_change_in = 1'b0;
        reg_write_in = 1'b0;
        reg_read_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        repeat (5) @(negedge mclk_in);
        reset_n_in = 1'b1;
        repeat (RC + 4) @(negedge mclk_in);
        t_regs();
        for (int f = 0; f < 4; f++) begin
            t_code(2'(f));
        end
        t_oeb();
        t_pwr(2'h1);
        t_pwr(2'h2);
        t_dcs();
        t_rst();
        report_and_stop();
    end
    // watchdog against a hang
    initial begin
        #20000;
        n_errors++;
        report_and_stop();
    end
endmodule
